// ### inc/risc_dma_consts.svh
// Offsets, field positions, codes and reset values of the sequencer
`ifndef RISC_DMA_CONSTS_SVH
`define RISC_DMA_CONSTS_SVH
`define REG_CTRL       8'h00
`define REG_START      8'h04
`define REG_PC         8'h08
`define REG_STATUS     8'h0C
`define CTRL_RUN       0
`define CTRL_CLR_ERR   1
`define F_CNT_HI       11
`define F_CNT_LO       0
`define F_BE_HI        15
`define F_BE_LO        12
`define F_CLR_HI       23
`define F_CLR_LO       20
`define F_SET_HI       19
`define F_SET_LO       16
`define F_IRQ          24
`define F_EOL          26
`define F_SOL          27
`define F_OP_HI        31
`define F_OP_LO        28
`define F_CNT3_HI      27
`define F_CNT3_LO      16
`define F_CODE_HI      3
`define F_CODE_LO      0
`define PACKED_FORMAT_CODE   4'h2
`define PLANAR_FORMAT_CODE   4'h3
`define EVEN_FIELD_NEXT_CODE 4'hC
`define ODD_FIELD_NEXT_CODE  4'h4
`define RST_START      32'h0000_0000
`define RST_STATUS     4'h0
`endif

// ### inc/risc_dma_pkg.sv
// Types of the video capture instruction sequencer
package risc_dma_pkg;
	typedef enum logic [6:0] {
		ST_IDLE   = 7'b0000001,
		ST_FETCH  = 7'b0000010,
		ST_EXEC   = 7'b0000100,
		ST_POP    = 7'b0001000,
		ST_WRITE  = 7'b0010000,
		ST_SYNC   = 7'b0100000,
		ST_FINISH = 7'b1000000
	} state_type;
	typedef enum logic [3:0] {
		OP_PACKED_WRITE           = 4'h1,
		OP_PACKED_SKIP            = 4'h2,
		OP_CONTINUED_PACKED_WRITE = 4'h5,
		OP_JUMP                   = 4'h7,
		OP_SYNC                   = 4'h8,
		OP_THREE_FIFO_PLANAR      = 4'h9
	} op_type;
endpackage

// ### tb/host_mem_model.sv
// Host memory answering fetches and pixel writes
`timescale 1ns/1ps
module host_mem_model (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Requests
	input  wire logic        fetch_req,
	input  wire logic [31:0] fetch_addr,
	input  wire logic        wr_req,
	// Answers
	output logic             fetch_ack,
	output logic      [31:0] fetch_data,
	output logic             wr_ack
);
	logic [31:0] mem [0:63];
	int          seed = 88;
	int          fw = 0;
	int          ww = 0;
	initial begin
		fetch_ack = 1'b0;
		wr_ack = 1'b0;
		fetch_data = 32'h0;
	end
	// Random latency; data toggles when not answering so stale values never match
	always @(posedge sys_clk) begin
		fetch_ack <= 1'b0;
		wr_ack <= 1'b0;
		fetch_data <= ~fetch_data;
		if (!rst && fetch_req && !fetch_ack) begin
			if (fw > 0) fw--;
			else begin
				fetch_ack <= 1'b1;
				fetch_data <= mem[fetch_addr[7:2]];
				fw = $unsigned($random(seed)) % 3;
			end
		end
		if (!rst && wr_req && !wr_ack) begin
			if (ww > 0) ww--;
			else begin
				wr_ack <= 1'b1;
				ww = $unsigned($random(seed)) % 3;
			end
		end
	end
endmodule // host_mem_model

// ### tb/risc_dma_sva.sv
// Port checker for the instruction sequencer
`timescale 1ns/1ps
module risc_dma_sva (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// Handshakes
	input wire logic        fetch_req,
	input wire logic        fetch_ack,
	input wire logic [31:0] fetch_addr,
	input wire logic        wr_req,
	input wire logic        wr_ack,
	input wire logic [31:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic [1:0]  wr_src,
	input wire logic        irq_event,
	// FIFO heads
	input wire logic        luma_fifo_pop,
	input wire logic        luma_fifo_valid,
	input wire logic        luma_fifo_code,
	input wire logic [31:0] luma_fifo_data,
	input wire logic        blue_chroma_fifo_pop,
	input wire logic        blue_chroma_fifo_valid,
	input wire logic        red_chroma_fifo_pop,
	input wire logic        red_chroma_fifo_valid
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Requests stand until answered
	property p_fh; fetch_req && !fetch_ack |=> fetch_req && $stable(fetch_addr); endproperty
	a_fh: assert property (p_fh) else $error("fetch dropped");
	property p_fn; fetch_req && fetch_ack ##1 fetch_req |-> fetch_addr == $past(fetch_addr) + 32'h4; endproperty
	a_fn: assert property (p_fn) else $error("fetch order");
	property p_wh; wr_req && !wr_ack |=> wr_req && $stable(wr_addr) && $stable(wr_data); endproperty
	a_wh: assert property (p_wh) else $error("write dropped");
	// Pops only from a word that is there
	property p_pv; (luma_fifo_pop |-> luma_fifo_valid) and (blue_chroma_fifo_pop |-> blue_chroma_fifo_valid) and (red_chroma_fifo_pop |-> red_chroma_fifo_valid); endproperty
	a_pv: assert property (p_pv) else $error("pop on empty");
	// Pixel words go out unaltered, upward
	property p_wd; luma_fifo_pop && !luma_fifo_code ##1 wr_req |-> wr_data == $past(luma_fifo_data) && wr_src == 2'h0; endproperty
	a_wd: assert property (p_wd) else $error("write data");
	property p_wa; wr_req && wr_ack ##1 !wr_req ##1 wr_req && wr_src == $past(wr_src, 2) |-> wr_addr == $past(wr_addr, 2) + 32'h4; endproperty
	a_wa: assert property (p_wa) else $error("write address step");
	property p_wp; $rose(wr_req) |-> $past(luma_fifo_pop || blue_chroma_fifo_pop || red_chroma_fifo_pop); endproperty
	a_wp: assert property (p_wp) else $error("write without pop");
	property p_ir; irq_event |=> !irq_event; endproperty
	a_ir: assert property (p_ir) else $error("event too long");
endmodule // risc_dma_sva

bind video_capture_risc_dma_sequencer risc_dma_sva i_sva (.*);

// ### tb/video_capture_risc_dma_sequencer_tb.sv
// Self-checking bench of the instruction sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
	$display("ERROR %0t got %h exp %h", $time, a, b); end end
module video_capture_risc_dma_sequencer_tb;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, fetch_addr, fetch_data, wr_addr, wr_data;
	logic        pready, pslverr, fetch_req, fetch_ack, wr_req, wr_ack;
	logic        irq_event, line_start_flag, line_end_flag;
	logic [3:0]  wr_be;
	logic [1:0]  wr_src;
	logic [2:0]  fv, fp;
	logic [32:0] fh [3];
	logic [32:0] fq [3][$];
	logic [69:0] eq [$];
	logic [69:0] ex;
	int          seed = 88;
	int          num_errors = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          irq_n = 0;
	int          sol_n = 0;
	int          eol_n = 0;
	always #4 sys_clk = ~sys_clk;
	video_capture_risc_dma_sequencer i_dut (
		.luma_fifo_data(fh[0][31:0]), .luma_fifo_code(fh[0][32]), .luma_fifo_valid(fv[0]),
		.luma_fifo_pop(fp[0]), .blue_chroma_fifo_data(fh[1][31:0]),
		.blue_chroma_fifo_code(fh[1][32]), .blue_chroma_fifo_valid(fv[1]),
		.blue_chroma_fifo_pop(fp[1]), .red_chroma_fifo_data(fh[2][31:0]),
		.red_chroma_fifo_code(fh[2][32]), .red_chroma_fifo_valid(fv[2]),
		.red_chroma_fifo_pop(fp[2]), .*);
	host_mem_model i_mem (.*);
	// FIFO heads; a popped word leaves at the edge
	always @(posedge sys_clk) begin
		for (int k = 0; k < 3; k++) begin
			if (fp[k] === 1'b1 && fq[k].size() != 0) void'(fq[k].pop_front());
			fv[k] <= fq[k].size() != 0;
			fh[k] <= fq[k].size() != 0 ? fq[k][0] : {1'b0, ~fh[k][31:0]};
		end
	end
	// Result watcher and hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (!rst && wr_req && wr_ack) begin
			ex = eq.size() != 0 ? eq.pop_front() : 'x;
			`CHK({wr_src, wr_be, wr_addr, wr_data}, ex)
		end
		if (!rst) begin
			irq_n += irq_event;
			sol_n += line_start_flag;
			eol_n += line_end_flag;
		end
		if (cyc == 5000) begin
			num_errors++;
			test_done();
		end
	end
	task automatic test_done();
		$display("tests_run %0d num_errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	// One field of stream: junk, format code, two pixels, next-field code
	task automatic field(input logic [31:0] a, input logic [3:0] c);
		logic [31:0] d;
		fq[0].push_back({1'b0, $random(seed)});
		fq[0].push_back({1'b1, 32'h2});
		for (int i = 0; i < 2; i++) begin
			d = $random(seed);
			fq[0].push_back({1'b0, d});
			eq.push_back({2'h0, 4'hF, a + 32'(4 * i), d});
		end
		fq[0].push_back({1'b1, 28'h0, c});
	endtask
	initial begin
		logic [31:0] r;
		logic        e;
		logic [31:0] px [6];
		fv = 3'h0;
		for (int k = 0; k < 3; k++) fh[k] = 33'h0;
		// Odd and even sequences, closed by a jump back
		i_mem.mem[16] = 32'h8000_0002;
		i_mem.mem[17] = 32'h1D01_F008;
		i_mem.mem[18] = 32'h0000_2000;
		i_mem.mem[19] = 32'h8000_000C;
		i_mem.mem[20] = 32'h8000_0002;
		i_mem.mem[21] = 32'h1D12_F008;
		i_mem.mem[22] = 32'h0000_3000;
		i_mem.mem[23] = 32'h8000_0004;
		i_mem.mem[24] = 32'h7000_0000;
		i_mem.mem[25] = 32'h0000_0040;
		for (int f = 0; f < 2; f++) begin
			field(32'h2000, 4'hC);
			field(32'h3000, 4'h4);
		end
		fq[1].push_back({1'b0, $random(seed)});
		fq[2].push_back({1'b0, $random(seed)});
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		apb(1'b1, 8'h04, 32'h40, r, e);
		apb(1'b1, 8'h00, 32'h1, r, e);
		while (eq.size() != 0) @(posedge sys_clk);
		repeat (20) @(posedge sys_clk);
		`CHK(fq[0].size() + fq[1].size() + fq[2].size(), 0)
		`CHK({irq_n, sol_n, eol_n}, {32'd4, 32'd4, 32'd4})
		$display("loop test done");
		apb(1'b0, 8'h0C, 32'h0, r, e);
		`CHK(r[6:0], 7'h12)
		apb(1'b0, 8'h04, 32'h0, r, e);
		`CHK(r, 32'h40)
		apb(1'b0, 8'h10, 32'h0, r, e);
		`CHK({e, r}, 33'h1_0000_0000)
		$display("register test done");
		// Planar program: sync, three-FIFO write, skip, continued write, bad opcode
		i_mem.mem[32] = 32'h8000_0003;
		i_mem.mem[33] = 32'h9000_3008;
		i_mem.mem[34] = 32'h0006_0004;
		i_mem.mem[35] = 32'h0000_4000;
		i_mem.mem[36] = 32'h0000_5000;
		i_mem.mem[37] = 32'h0000_6000;
		i_mem.mem[38] = 32'h2000_0004;
		i_mem.mem[39] = 32'h5000_F004;
		i_mem.mem[40] = 32'hF000_0000;
		// Stop lets the waiting sync end; chroma data only once the engine is idle
		apb(1'b1, 8'h00, 32'h0, r, e);
		apb(1'b1, 8'h04, 32'h80, r, e);
		fq[0].push_back({1'b1, 32'h2});
		repeat (8) @(posedge sys_clk);
		for (int i = 0; i < 6; i++) px[i] = $random(seed);
		fq[0].push_back({1'b1, 32'h3});
		fq[0].push_back({1'b0, px[0]});
		fq[0].push_back({1'b0, px[1]});
		fq[0].push_back({1'b0, $random(seed)});
		fq[0].push_back({1'b0, px[5]});
		fq[1].push_back({1'b0, $random(seed)});
		fq[1].push_back({1'b0, px[2]});
		fq[2].push_back({1'b0, $random(seed)});
		fq[2].push_back({1'b0, px[3]});
		fq[2].push_back({1'b0, px[4]});
		eq.push_back({2'h0, 4'h3, 32'h4000, px[0]});
		eq.push_back({2'h0, 4'h3, 32'h4004, px[1]});
		eq.push_back({2'h1, 4'h3, 32'h5000, px[2]});
		eq.push_back({2'h2, 4'h3, 32'h6000, px[3]});
		eq.push_back({2'h2, 4'h3, 32'h6004, px[4]});
		eq.push_back({2'h0, 4'hF, 32'h6008, px[5]});
		apb(1'b1, 8'h00, 32'h1, r, e);
		while (eq.size() != 0) @(posedge sys_clk);
		repeat (20) @(posedge sys_clk);
		`CHK(fq[0].size() + fq[1].size() + fq[2].size(), 0)
		apb(1'b0, 8'h0C, 32'h0, r, e);
		`CHK(r, 32'h0000_00E2)
		apb(1'b1, 8'h00, 32'h2, r, e);
		apb(1'b0, 8'h0C, 32'h0, r, e);
		`CHK(r, 32'h0000_00C2)
		$display("planar test done");
		test_done();
	end
endmodule // video_capture_risc_dma_sequencer_tb

// ### verilog/video_capture_risc_dma_sequencer.sv
// Instruction sequencer of the video capture DMA engine with APB registers
//
// Operation
// - Sync aligns program with FIFO codes
// - Engine loops program forever via jumps
// - Decode write, continued write, skip, sync, jump
// - Decode planar write alongside packed write; no planar skip
// - FIFO status codes switch packed/planar mode
// - Packed write: opcode 0001, two words
// - First word field layout for writes
// - Planar write: opcode 1001, five words
// - Planar second word holds chroma counts
// - Luma address to LUMA_FIFO, red to RED_CHROMA_FIFO
// - Run bit set while idle triggers fetch from start address
// - FIFO words reach bus unaltered
// - Engine discards data to resynchronise
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`include "risc_dma_consts.svh"

module video_capture_risc_dma_sequencer (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Instruction fetch through bus initiator
	output logic             fetch_req,
	output logic      [31:0] fetch_addr,
	input  wire logic        fetch_ack,
	input  wire logic [31:0] fetch_data,
	// Pixel write through bus initiator
	output logic             wr_req,
	output logic      [31:0] wr_addr,
	output logic      [31:0] wr_data,
	output logic      [3:0]  wr_be,
	output logic      [1:0]  wr_src,
	input  wire logic        wr_ack,
	// Luma FIFO
	input  wire logic [31:0] luma_fifo_data,
	input  wire logic        luma_fifo_code,
	input  wire logic        luma_fifo_valid,
	output logic             luma_fifo_pop,
	// Blue chroma FIFO
	input  wire logic [31:0] blue_chroma_fifo_data,
	input  wire logic        blue_chroma_fifo_code,
	input  wire logic        blue_chroma_fifo_valid,
	output logic             blue_chroma_fifo_pop,
	// Red chroma FIFO
	input  wire logic [31:0] red_chroma_fifo_data,
	input  wire logic        red_chroma_fifo_code,
	input  wire logic        red_chroma_fifo_valid,
	output logic             red_chroma_fifo_pop,
	// Events
	output logic             irq_event,
	output logic             line_start_flag,
	output logic             line_end_flag
);

	// Words an instruction occupies, from its opcode
	function automatic logic [2:0] op_words(input logic [3:0] op);
		unique case (op)
			risc_dma_pkg::OP_PACKED_WRITE:      op_words = 3'd2;
			risc_dma_pkg::OP_JUMP:              op_words = 3'd2;
			risc_dma_pkg::OP_THREE_FIFO_PLANAR: op_words = 3'd5;
			default:                            op_words = 3'd1;
		endcase
	endfunction

	// Byte count to whole words, rounding a partial word up
	function automatic logic [10:0] to_words(input logic [11:0] bytes);
		logic [12:0] sum;
		sum = {1'b0, bytes} + 13'h0003;
		to_words = sum[12:2];
	endfunction

	risc_dma_pkg::state_type state_q, state_d;
	logic [31:0] ibuf_q [5];
	logic [31:0] ibuf_d [5];
	logic [31:0] start_q, start_d, pc_q, pc_d, addr_q, addr_d, data_q, data_d;
	logic [2:0]  idx_q, idx_d, need_q, need_d;
	logic [1:0]  sel_q, sel_d;
	logic [10:0] left_q, left_d;
	logic [3:0]  pstat_q, pstat_d;
	logic        run_q, run_d, err_q, err_d, planar_q, planar_d, skip_q, skip_d;
	logic        irq_q, irq_d, sol_q, sol_d, eol_q, eol_d;
	logic [31:0] rdata_q, rdata_d;
	logic [31:0] f_data;
	logic        f_code, f_valid;
	logic [3:0]  op;
	logic        apb_wr, apb_rd, hit;
	logic        err_set;

	assign op     = ibuf_q[0][`F_OP_HI:`F_OP_LO];
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && !penable && !pwrite;
	assign hit    = (paddr == `REG_CTRL) || (paddr == `REG_START) ||
			(paddr == `REG_PC) || (paddr == `REG_STATUS);

	// Zero-wait slave; data latched in setup so it is a flip-flop in access
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata  = rdata_q;

	// Selected FIFO; bit 0 stays bit 0 all the way to the bus
	always_comb begin
		unique case (sel_q)
			2'd1:    begin f_data = blue_chroma_fifo_data; f_code = blue_chroma_fifo_code;
				f_valid = blue_chroma_fifo_valid; end
			2'd2:    begin f_data = red_chroma_fifo_data; f_code = red_chroma_fifo_code;
				f_valid = red_chroma_fifo_valid; end
			default: begin f_data = luma_fifo_data; f_code = luma_fifo_code;
				f_valid = luma_fifo_valid; end
		endcase
	end

	// Pops: selected FIFO while moving, every FIFO while syncing
	always_comb begin
		luma_fifo_pop        = 1'b0;
		blue_chroma_fifo_pop = 1'b0;
		red_chroma_fifo_pop  = 1'b0;
		if (state_q == risc_dma_pkg::ST_SYNC) begin
			luma_fifo_pop        = luma_fifo_valid;
			blue_chroma_fifo_pop = blue_chroma_fifo_valid;
			red_chroma_fifo_pop  = red_chroma_fifo_valid;
		end else if (state_q == risc_dma_pkg::ST_POP && left_q != 11'd0) begin
			luma_fifo_pop        = (sel_q == 2'd0) && luma_fifo_valid;
			blue_chroma_fifo_pop = (sel_q == 2'd1) && blue_chroma_fifo_valid;
			red_chroma_fifo_pop  = (sel_q == 2'd2) && red_chroma_fifo_valid;
		end
	end

	assign fetch_req  = (state_q == risc_dma_pkg::ST_FETCH);
	assign fetch_addr = pc_q;
	assign wr_req     = (state_q == risc_dma_pkg::ST_WRITE);
	assign wr_addr    = addr_q;
	assign wr_data    = data_q;
	assign wr_be      = ibuf_q[0][`F_BE_HI:`F_BE_LO];
	assign wr_src     = sel_q;
	assign irq_event  = irq_q;
	assign line_start_flag = sol_q;
	assign line_end_flag   = eol_q;

	// Next state of the whole sequencer and its registers
	always_comb begin
		state_d  = state_q;
		ibuf_d   = ibuf_q;
		start_d  = start_q;
		pc_d     = pc_q;
		addr_d   = addr_q;
		data_d   = data_q;
		idx_d    = idx_q;
		need_d   = need_q;
		sel_d    = sel_q;
		left_d   = left_q;
		pstat_d  = pstat_q;
		run_d    = run_q;
		err_d    = err_q;
		planar_d = planar_q;
		skip_d   = skip_q;
		irq_d    = 1'b0;
		sol_d    = 1'b0;
		eol_d    = 1'b0;
		rdata_d  = rdata_q;
		err_set  = 1'b0;

		// Register reads, captured in the setup cycle
		if (apb_rd) begin
			unique case (paddr)
				`REG_CTRL:   rdata_d = {31'h0, run_q};
				`REG_START:  rdata_d = start_q;
				`REG_PC:     rdata_d = pc_q;
				`REG_STATUS: rdata_d = {18'h0, state_q, planar_q, err_q,
						run_q, pstat_q};
				default:     rdata_d = 32'h0000_0000;
			endcase
		end

		unique case (state_q)
			risc_dma_pkg::ST_IDLE: begin
				if (run_q) begin
					pc_d    = start_q;
					idx_d   = 3'd0;
					state_d = risc_dma_pkg::ST_FETCH;
				end
			end
			risc_dma_pkg::ST_FETCH: begin
				if (fetch_ack) begin
					ibuf_d[idx_q] = fetch_data;
					pc_d          = pc_q + 32'h0000_0004;
					idx_d         = idx_q + 3'd1;
					if (idx_q == 3'd0)
						need_d = op_words(fetch_data[`F_OP_HI:`F_OP_LO]);
					if ((idx_q == 3'd0 &&
							op_words(fetch_data[`F_OP_HI:`F_OP_LO]) == 3'd1) ||
							(idx_q != 3'd0 && idx_q + 3'd1 == need_q))
						state_d = risc_dma_pkg::ST_EXEC;
				end
			end
			risc_dma_pkg::ST_EXEC: begin
				idx_d  = 3'd0;
				sel_d  = 2'd0;
				sol_d  = ibuf_q[0][`F_SOL];
				skip_d = 1'b0;
				left_d = to_words(ibuf_q[0][`F_CNT_HI:`F_CNT_LO]);
				// Bit 25 and unlisted fields are never looked at
				unique case (op)
					risc_dma_pkg::OP_PACKED_WRITE: begin
						addr_d  = ibuf_q[1];
						state_d = risc_dma_pkg::ST_POP;
					end
					risc_dma_pkg::OP_CONTINUED_PACKED_WRITE:
						state_d = risc_dma_pkg::ST_POP;
					risc_dma_pkg::OP_PACKED_SKIP: begin
						skip_d  = 1'b1;
						state_d = risc_dma_pkg::ST_POP;
					end
					risc_dma_pkg::OP_THREE_FIFO_PLANAR: begin
						addr_d  = ibuf_q[2];
						state_d = risc_dma_pkg::ST_POP;
					end
					risc_dma_pkg::OP_JUMP: begin
						pc_d    = ibuf_q[1];
						state_d = risc_dma_pkg::ST_FINISH;
					end
					risc_dma_pkg::OP_SYNC:
						state_d = risc_dma_pkg::ST_SYNC;
					default: begin
						// Unknown opcode stops the engine rather than guess
						err_d   = 1'b1;
						err_set = 1'b1;
						run_d   = 1'b0;
						state_d = risc_dma_pkg::ST_IDLE;
					end
				endcase
			end
			risc_dma_pkg::ST_POP: begin
				if (left_q == 11'd0) begin
					// Planar write steps luma, blue, red
					if (op == risc_dma_pkg::OP_THREE_FIFO_PLANAR && sel_q != 2'd2) begin
						sel_d = sel_q + 2'd1;
						if (sel_q == 2'd0) begin
							left_d = to_words(ibuf_q[1][`F_CNT_HI:`F_CNT_LO]);
							addr_d = ibuf_q[3];
						end else begin
							left_d = to_words(ibuf_q[1][`F_CNT3_HI:`F_CNT3_LO]);
							addr_d = ibuf_q[4];
						end
					end else begin
						state_d = risc_dma_pkg::ST_FINISH;
					end
				end else if (f_valid) begin
					if (f_code) begin
						// Stream ran short: adopt the code and end early
						if (f_data[`F_CODE_HI:`F_CODE_LO] == `PLANAR_FORMAT_CODE)
							planar_d = 1'b1;
						else if (f_data[`F_CODE_HI:`F_CODE_LO] == `PACKED_FORMAT_CODE)
							planar_d = 1'b0;
						state_d = risc_dma_pkg::ST_FINISH;
					end else if (skip_q) begin
						left_d = left_q - 11'd1;
					end else begin
						data_d  = f_data;
						state_d = risc_dma_pkg::ST_WRITE;
					end
				end
			end
			risc_dma_pkg::ST_WRITE: begin
				if (wr_ack) begin
					addr_d  = addr_q + 32'h0000_0004;
					left_d  = left_q - 11'd1;
					state_d = risc_dma_pkg::ST_POP;
				end
			end
			risc_dma_pkg::ST_SYNC: begin
				// Data ahead of the expected code is thrown away
				if (luma_fifo_valid && luma_fifo_code) begin
					if (luma_fifo_data[`F_CODE_HI:`F_CODE_LO] == `PLANAR_FORMAT_CODE)
						planar_d = 1'b1;
					else if (luma_fifo_data[`F_CODE_HI:`F_CODE_LO] == `PACKED_FORMAT_CODE)
						planar_d = 1'b0;
					if (luma_fifo_data[`F_CODE_HI:`F_CODE_LO] ==
							ibuf_q[0][`F_CODE_HI:`F_CODE_LO])
						state_d = risc_dma_pkg::ST_FINISH;
				end
			end
			risc_dma_pkg::ST_FINISH: begin
				pstat_d = (pstat_q & ~ibuf_q[0][`F_CLR_HI:`F_CLR_LO]) |
						ibuf_q[0][`F_SET_HI:`F_SET_LO];
				irq_d   = ibuf_q[0][`F_IRQ];
				eol_d   = ibuf_q[0][`F_EOL];
				idx_d   = 3'd0;
				state_d = run_q ? risc_dma_pkg::ST_FETCH : risc_dma_pkg::ST_IDLE;
			end
		endcase

		// Register writes; a stop lets the current instruction end
		if (apb_wr) begin
			if (paddr == `REG_CTRL) begin
				run_d = pwdata[`CTRL_RUN];
				if (pwdata[`CTRL_CLR_ERR] && !err_set) // A fault in the same cycle wins
					err_d = 1'b0;
			end
			if (paddr == `REG_START)
				start_d = pwdata;
		end
	end

	// Register stage
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q  <= risc_dma_pkg::ST_IDLE;
			for (int i = 0; i < 5; i++)
				ibuf_q[i] <= 32'h0000_0000;
			start_q  <= `RST_START;
			pc_q     <= `RST_START;
			addr_q   <= 32'h0000_0000;
			data_q   <= 32'h0000_0000;
			idx_q    <= 3'd0;
			need_q   <= 3'd1;
			sel_q    <= 2'd0;
			left_q   <= 11'd0;
			pstat_q  <= `RST_STATUS;
			run_q    <= 1'b0;
			err_q    <= 1'b0;
			planar_q <= 1'b0;
			skip_q   <= 1'b0;
			irq_q    <= 1'b0;
			sol_q    <= 1'b0;
			eol_q    <= 1'b0;
			rdata_q  <= 32'h0000_0000;
		end else begin
			state_q  <= state_d;
			ibuf_q   <= ibuf_d;
			start_q  <= start_d;
			pc_q     <= pc_d;
			addr_q   <= addr_d;
			data_q   <= data_d;
			idx_q    <= idx_d;
			need_q   <= need_d;
			sel_q    <= sel_d;
			left_q   <= left_d;
			pstat_q  <= pstat_d;
			run_q    <= run_d;
			err_q    <= err_d;
			planar_q <= planar_d;
			skip_q   <= skip_d;
			irq_q    <= irq_d;
			sol_q    <= sol_d;
			eol_q    <= eol_d;
			rdata_q  <= rdata_d;
		end
	end

endmodule // video_capture_risc_dma_sequencer
